// ### rtl/scr_call_return.sv
`timescale 1ns/100ps
`include "scr_cfg.svh"


module scr_call_return (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [15:0] i_program_counter,
  input  wire logic [15:0] i_stack_pointer,
  input  wire logic [7:0]  i_flags,
  input  wire logic [7:0]  i_mem_rdata,
  output logic [15:0]      o_mem_addr,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic [7:0]       o_mem_wdata,
  output logic [15:0]      o_program_counter,
  output logic [15:0]      o_stack_pointer,
  output logic             o_busy,
  output logic             o_done
);

  // ==========================================================
  // State
  scr_pkg::scr_state_e state, next_state;
  scr_pkg::scr_kind_e  kind, next_kind;
  logic [2:0]  t, next_t;
  logic [2:0]  len, next_len;
  logic        taken, next_taken;
  logic [15:0] pc0, next_pc0;
  logic [15:0] sp0, next_sp0;
  logic [7:0]  lo, next_lo;
  logic [15:0] next_mem_addr;
  logic        next_mem_rd;
  logic        next_mem_wr;
  logic [7:0]  next_mem_wdata;
  logic [15:0] next_program_counter;
  logic [15:0] next_stack_pointer;
  logic        next_busy;
  logic        next_done;
  logic        cond_ok;
  logic        last;
  logic        is_call;
  logic        is_callcc;
  logic        is_retcc;
  logic [15:0] ret_addr;

  scr_cond_eval u_cond (
    .i_condition_field (i_opcode[`SCR_COND_MSB:`SCR_COND_LSB]),
    .i_flags           (i_flags),
    .o_true            (cond_ok)
  );

  // ==========================================================
  // Decode
  assign is_call   = (i_opcode == `SCR_OP_CALL);
  assign is_callcc = ((i_opcode & `SCR_OP_COND_MASK) == `SCR_OP_CALLCC);
  assign is_retcc  = ((i_opcode & `SCR_OP_COND_MASK) == `SCR_OP_RETCC);
  assign last      = (t == len - `SCR_T_ONE);
  assign ret_addr  = pc0 + `SCR_LEN_CALL;

  // ==========================================================
  // Sequencer; flags are only read, never written
  always_comb begin
    next_state     = state;
    next_kind      = kind;
    next_t         = last ? 3'h0 : t + `SCR_T_ONE;
    next_len       = len;
    next_taken     = taken;
    next_pc0       = pc0;
    next_sp0       = sp0;
    next_lo        = lo;
    next_mem_addr  = o_mem_addr;
    next_mem_rd    = o_mem_rd;
    next_mem_wr    = o_mem_wr;
    next_mem_wdata = o_mem_wdata;
    next_program_counter = o_program_counter;
    next_stack_pointer   = o_stack_pointer;
    next_busy      = o_busy;
    next_done      = 1'b0;
    case (state)
      scr_pkg::SCR_IDLE: begin
        next_t = 3'h0;
        if (i_start && (is_call || is_callcc || i_opcode == `SCR_OP_RET || is_retcc)) begin
          next_kind  = is_call ? scr_pkg::SCR_CALL :
                       is_callcc ? scr_pkg::SCR_CALLCC :
                       is_retcc ? scr_pkg::SCR_RETCC : scr_pkg::SCR_RET;
          next_taken = (is_callcc || is_retcc) ? cond_ok : 1'b1;
          next_len   = is_retcc ? `SCR_T_FETCH_RC : `SCR_T_FETCH;
          next_pc0   = i_program_counter;
          next_sp0   = i_stack_pointer;
          next_state = scr_pkg::SCR_FETCH;
          next_busy  = 1'b1;
        end
      end
      scr_pkg::SCR_FETCH: begin
        if (last) begin
          next_len = `SCR_T_MEM;
          if (kind == scr_pkg::SCR_CALL || kind == scr_pkg::SCR_CALLCC) begin
            next_mem_addr = pc0 + `SCR_STEP1;
            next_mem_rd   = 1'b1;
            next_state    = scr_pkg::SCR_RDLO;
          end else if (taken) begin
            next_mem_addr = sp0;
            next_mem_rd   = 1'b1;
            next_state    = scr_pkg::SCR_RDLO;
          end else begin
            next_program_counter = pc0 + `SCR_LEN_RET;
            next_stack_pointer   = sp0;
            next_done  = 1'b1;
            next_busy  = 1'b0;
            next_state = scr_pkg::SCR_IDLE;
          end
        end
      end
      scr_pkg::SCR_RDLO: begin
        if (last) begin
          next_lo       = i_mem_rdata;
          next_mem_addr = o_mem_addr + `SCR_STEP1;
          next_len      = (kind != scr_pkg::SCR_RET && kind != scr_pkg::SCR_RETCC && taken)
                          ? `SCR_T_TGT_HI : `SCR_T_MEM;
          next_state    = scr_pkg::SCR_RDHI;
        end
      end
      scr_pkg::SCR_RDHI: begin
        if (last) begin
          next_mem_rd = 1'b0;
          next_len    = `SCR_T_MEM;
          if (kind == scr_pkg::SCR_RET || kind == scr_pkg::SCR_RETCC) begin
            next_program_counter = {i_mem_rdata, lo};
            next_stack_pointer   = sp0 + `SCR_STEP2;
            next_done  = 1'b1;
            next_busy  = 1'b0;
            next_state = scr_pkg::SCR_IDLE;
          end else if (taken) begin
            next_program_counter = {i_mem_rdata, lo};
            next_mem_addr  = sp0 - `SCR_STEP1;
            next_mem_wr    = 1'b1;
            next_mem_wdata = ret_addr[15:8];
            next_state     = scr_pkg::SCR_WRHI;
          end else begin
            next_program_counter = ret_addr;
            next_stack_pointer   = sp0;
            next_done  = 1'b1;
            next_busy  = 1'b0;
            next_state = scr_pkg::SCR_IDLE;
          end
        end
      end
      scr_pkg::SCR_WRHI: begin
        if (last) begin
          next_mem_addr  = sp0 - `SCR_STEP2;
          next_mem_wdata = ret_addr[7:0];
          next_state     = scr_pkg::SCR_WRLO;
        end
      end
      scr_pkg::SCR_WRLO: begin
        if (last) begin
          next_mem_wr = 1'b0;
          next_stack_pointer = sp0 - `SCR_STEP2;
          next_done   = 1'b1;
          next_busy   = 1'b0;
          next_state  = scr_pkg::SCR_IDLE;
        end
      end
      default: begin
        next_state = scr_pkg::SCR_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state             <= scr_pkg::SCR_IDLE;
      kind              <= scr_pkg::SCR_CALL;
      t                 <= 3'h0;
      len               <= `SCR_T_FETCH;
      taken             <= 1'b0;
      pc0               <= 16'h0000;
      sp0               <= 16'h0000;
      lo                <= 8'h00;
      o_mem_addr        <= 16'h0000;
      o_mem_rd          <= 1'b0;
      o_mem_wr          <= 1'b0;
      o_mem_wdata       <= 8'h00;
      o_program_counter <= 16'h0000;
      o_stack_pointer   <= 16'h0000;
      o_busy            <= 1'b0;
      o_done            <= 1'b0;
    end else begin
      state             <= next_state;
      kind              <= next_kind;
      t                 <= next_t;
      len               <= next_len;
      taken             <= next_taken;
      pc0               <= next_pc0;
      sp0               <= next_sp0;
      lo                <= next_lo;
      o_mem_addr        <= next_mem_addr;
      o_mem_rd          <= next_mem_rd;
      o_mem_wr          <= next_mem_wr;
      o_mem_wdata       <= next_mem_wdata;
      o_program_counter <= next_program_counter;
      o_stack_pointer   <= next_stack_pointer;
      o_busy            <= next_busy;
      o_done            <= next_done;
    end
  end

  // ==========================================================
  // Checking helpers
  logic [4:0] cyc;
  logic       touched;

  always_ff @(posedge i_clk) begin
    if (i_reset || !o_busy) begin
      cyc     <= 5'h00;
      touched <= 1'b0;
    end else begin
      cyc     <= (cyc == `SCR_CYC_MAX) ? cyc : cyc + `SCR_CYC_ONE;
      touched <= touched | o_mem_rd | o_mem_wr;
    end
  end

  sequence s_hi_write;
    (o_mem_wr && state == scr_pkg::SCR_WRHI) [*3];
  endsequence

  sequence s_lo_write;
    (o_mem_wr && state == scr_pkg::SCR_WRLO) [*3];
  endsequence

  push_order_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(state == scr_pkg::SCR_WRHI) |-> s_hi_write ##1 s_lo_write ##1 o_done)
    else $error("push sequence wrong");

  push_addr_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(state == scr_pkg::SCR_WRLO) |-> o_mem_addr == $past(o_mem_addr) - `SCR_STEP1)
    else $error("low byte not below high byte");

  call_time_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_done && taken && (kind == scr_pkg::SCR_CALL || kind == scr_pkg::SCR_CALLCC)
    |-> cyc == `SCR_TOT_CALL)
    else $error("taken call length wrong");

  short_time_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_done && (kind == scr_pkg::SCR_RET || (kind == scr_pkg::SCR_CALLCC && !taken))
    |-> cyc == `SCR_TOT_SHORT)
    else $error("ten state case length wrong");

  retcc_time_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_done && kind == scr_pkg::SCR_RETCC
    |-> cyc == (taken ? `SCR_TOT_RC_T : `SCR_TOT_RC_F))
    else $error("conditional return length wrong");

  call_jump_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_done && taken && kind != scr_pkg::SCR_RET && kind != scr_pkg::SCR_RETCC
    |-> o_stack_pointer == sp0 - `SCR_STEP2 && $past(o_mem_wdata) == ret_addr[7:0])
    else $error("call result wrong");

  call_skip_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_done && !taken && kind == scr_pkg::SCR_CALLCC
    |-> o_stack_pointer == sp0 && o_program_counter == ret_addr && !$past(o_mem_wr, 2))
    else $error("untaken call touched stack");

  ret_pop_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_done && taken && (kind == scr_pkg::SCR_RET || kind == scr_pkg::SCR_RETCC)
    |-> o_stack_pointer == sp0 + `SCR_STEP2)
    else $error("return pointer wrong");

  ret_skip_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_done && !taken && kind == scr_pkg::SCR_RETCC
    |-> o_program_counter == pc0 + `SCR_LEN_RET && !touched)
    else $error("untaken return wrong");

  one_access_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !(o_mem_rd && o_mem_wr))
    else $error("read and write together");

endmodule

// ### rtl/scr_cfg.svh
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// Opcodes and condition opcode pattern
`define SCR_OP_CALL     8'hCD
`define SCR_OP_RET      8'hC9
`define SCR_OP_COND_MASK 8'hC7
`define SCR_OP_CALLCC   8'hC4
`define SCR_OP_RETCC    8'hC0
`define SCR_COND_LSB    3
`define SCR_COND_MSB    5

// Flag bit positions
`define SCR_FLAG_S      7
`define SCR_FLAG_Z      6
`define SCR_FLAG_PV     2
`define SCR_FLAG_C      0

// Clock states per machine cycle
`define SCR_T_FETCH     3'h4
`define SCR_T_FETCH_RC  3'h5
`define SCR_T_MEM       3'h3
`define SCR_T_TGT_HI    3'h4
`define SCR_T_ONE       3'h1

// Address steps
`define SCR_STEP1       16'h0001
`define SCR_STEP2       16'h0002
`define SCR_LEN_CALL    16'h0003
`define SCR_LEN_RET     16'h0001

// Expected totals in clock states
`define SCR_TOT_CALL    5'h11
`define SCR_TOT_SHORT   5'h0A
`define SCR_TOT_RC_T    5'h0B
`define SCR_TOT_RC_F    5'h05
`define SCR_CYC_ONE     5'h01
`define SCR_CYC_MAX     5'h1F

`endif

// ### rtl/scr_pkg.sv
package scr_pkg;

  typedef enum logic [2:0] {
    SCR_IDLE  = 3'b000,
    SCR_FETCH = 3'b001,
    SCR_RDLO  = 3'b010,
    SCR_RDHI  = 3'b011,
    SCR_WRHI  = 3'b100,
    SCR_WRLO  = 3'b101
  } scr_state_e;

  typedef enum logic [1:0] {
    SCR_CALL   = 2'b00,
    SCR_CALLCC = 2'b01,
    SCR_RET    = 2'b10,
    SCR_RETCC  = 2'b11
  } scr_kind_e;

endpackage

// ### rtl/scr_cond_eval.sv
`timescale 1ns/100ps
`include "scr_cfg.svh"

module scr_cond_eval (
  input  wire logic [2:0] i_condition_field,
  input  wire logic [7:0] i_flags,
  output logic            o_true
);

  // ==========================================================
  // Condition table
  always_comb begin
    case (i_condition_field)
      3'h0:    o_true = ~i_flags[`SCR_FLAG_Z];
      3'h1:    o_true = i_flags[`SCR_FLAG_Z];
      3'h2:    o_true = ~i_flags[`SCR_FLAG_C];
      3'h3:    o_true = i_flags[`SCR_FLAG_C];
      3'h4:    o_true = ~i_flags[`SCR_FLAG_PV];
      3'h5:    o_true = i_flags[`SCR_FLAG_PV];
      3'h6:    o_true = ~i_flags[`SCR_FLAG_S];
      3'h7:    o_true = i_flags[`SCR_FLAG_S];
      default: o_true = 1'b0;
    endcase
  end

endmodule

// ### tb/scr_mem_model.sv
`timescale 1ns/100ps
// ====
// Byte memory for program and stack
module scr_mem_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'hA5;
  always @(posedge i_clk) begin
    if (i_wr) mem[i_addr] <= i_wdata;
    if (i_rd) last <= mem[i_addr];
  end
  // Released data lines show no stale byte
  assign o_rdata = i_rd ? mem[i_addr] : ~last;
endmodule

// ### tb/tb_subroutine_call_return_control.sv
`timescale 1ns/100ps
`include "scr_cfg.svh"
module tb_subroutine_call_return_control;
  logic        i_clk, i_reset, i_start, o_mem_rd, o_mem_wr, o_busy, o_done, t;
  logic [7:0]  i_opcode, i_flags, i_mem_rdata, o_mem_wdata, f, fl;
  logic [15:0] i_program_counter, i_stack_pointer, o_mem_addr, o_program_counter;
  logic [15:0] o_stack_pointer, base, stk, tg;
  logic [2:0]  cond;
  int          num_errors = 0;
  int          tests_run = 0;
  int          n;
  // ====
  // Design and memory
  scr_call_return dut (
    .i_clk             (i_clk),
    .i_reset           (i_reset),
    .i_start           (i_start),
    .i_opcode          (i_opcode),
    .i_program_counter (i_program_counter),
    .i_stack_pointer   (i_stack_pointer),
    .i_flags           (i_flags),
    .i_mem_rdata       (i_mem_rdata),
    .o_mem_addr        (o_mem_addr),
    .o_mem_rd          (o_mem_rd),
    .o_mem_wr          (o_mem_wr),
    .o_mem_wdata       (o_mem_wdata),
    .o_program_counter (o_program_counter),
    .o_stack_pointer   (o_stack_pointer),
    .o_busy            (o_busy),
    .o_done            (o_done)
  );
  scr_mem_model mem_i (
    .i_clk   (i_clk),
    .i_addr  (o_mem_addr),
    .i_rd    (o_mem_rd),
    .i_wr    (o_mem_wr),
    .i_wdata (o_mem_wdata),
    .o_rdata (i_mem_rdata)
  );
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // ====
  // Tasks
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic setw(input logic [15:0] a, input logic [15:0] v);
    logic [15:0] b;
    b = a + 16'h0001;
    mem_i.mem[a] = v[7:0];
    mem_i.mem[b] = v[15:8];
  endtask
  function automatic logic [15:0] getw(input logic [15:0] a);
    logic [15:0] b;
    b = a + 16'h0001;
    return {mem_i.mem[b], mem_i.mem[a]};
  endfunction
  // Starts at a falling edge, counts busy states until done
  task automatic run(input logic [7:0] op, input logic [15:0] p, input logic [15:0] s,
                     input logic [7:0] fi);
    int k;
    i_start = 1'b1;
    i_opcode = op;
    i_program_counter = p;
    i_stack_pointer = s;
    i_flags = fi;
    @(negedge i_clk);
    i_start = 1'b0;
    n = 0;
    k = 0;
    while (o_done !== 1'b1 && k < 60) begin
      if (o_busy === 1'b1) n++;
      k++;
      @(negedge i_clk);
    end
    if (o_done !== 1'b1) num_errors++;
  endtask
  // ====
  // Tests
  initial begin
    repeat (3000) @(posedge i_clk);
    num_errors++;
    results;
  end
  initial begin
    i_reset = 1'b1;
    i_start = 1'b0;
    i_opcode = 8'h00;
    i_program_counter = 16'h0000;
    i_stack_pointer = 16'h0000;
    i_flags = 8'h00;
    repeat (10) @(negedge i_clk);
    i_reset = 1'b0;
    chk({o_busy, o_done, o_mem_rd, o_mem_wr, 12'h000}, 16'h0000);
    chk(o_program_counter, 16'h0000);
    setw(16'h1A48, 16'h2135);
    run(`SCR_OP_CALL, 16'h1A47, 16'h3002, 8'hFF);
    chk(n[15:0], 16'h0011);
    chk(o_program_counter, 16'h2135);
    chk(o_stack_pointer, 16'h3000);
    chk(getw(16'h3000), 16'h1A4A);
    run(`SCR_OP_RET, 16'h2140, 16'h3000, 8'h00);
    chk(n[15:0], 16'h000A);
    chk(o_program_counter, 16'h1A4A);
    chk(o_stack_pointer, 16'h3002);
    $display("test call_ret done");
    setw(16'hFFFF, 16'hBEEF);
    run(`SCR_OP_CALL, 16'hFFFE, 16'h0001, 8'h00);
    chk(o_program_counter, 16'hBEEF);
    chk(o_stack_pointer, 16'hFFFF);
    chk(getw(16'hFFFF), 16'h0001);
    run(`SCR_OP_RET, 16'hBEEF, 16'hFFFF, 8'h00);
    chk(o_program_counter, 16'h0001);
    chk(o_stack_pointer, 16'h0001);
    $display("test wrap done");
    for (int i = 0; i < 16; i++) begin
      cond = i[3:1];
      t = i[0];
      f = 8'h01 << ((cond[2:1] == 2'd0) ? `SCR_FLAG_Z : (cond[2:1] == 2'd1) ? `SCR_FLAG_C :
                    (cond[2:1] == 2'd2) ? `SCR_FLAG_PV : `SCR_FLAG_S);
      fl = (cond[0] == t) ? f : ~f;
      base = 16'h4000 + {9'h000, cond, 4'h0};
      stk = 16'h8000 + {9'h000, cond, 4'h0};
      tg = 16'h5A00 + {13'h0000, cond};
      setw(base + 16'h0001, tg);
      setw(stk - 16'h0002, 16'hC3C3);
      run(`SCR_OP_CALLCC | {2'b00, cond, 3'b000}, base, stk, fl);
      chk(n[15:0], t ? 16'h0011 : 16'h000A);
      chk(o_program_counter, t ? tg : base + 16'h0003);
      chk(o_stack_pointer, t ? stk - 16'h0002 : stk);
      chk(getw(stk - 16'h0002), t ? base + 16'h0003 : 16'hC3C3);
      run(`SCR_OP_RETCC | {2'b00, cond, 3'b000}, 16'h6000, stk - 16'h0002, fl);
      chk(n[15:0], t ? 16'h000B : 16'h0005);
      chk(o_program_counter, t ? base + 16'h0003 : 16'h6001);
      chk(o_stack_pointer, t ? stk : stk - 16'h0002);
    end
    $display("test conditions done");
    results;
  end
endmodule
